// ---- core/asrp_pkg.sv ----
// Shared constants and types for the serial register port: device end and
// host end.
// Assumes both ends run on the same 100 MHz mclk, with the serial clock seen
// as a sampled input.
package asrp_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned CMD_BITS = 8;      // Command word width
    localparam int unsigned DATA_BITS = 24;    // Widest register width
    localparam int unsigned REG_COUNT = 16;    // Register address space
    localparam int unsigned ONES_RESET = 32;   // Ones run that resets port
    localparam int unsigned ONES_CNT_W = 6;    // Width of ones counter
    localparam logic [5:0] ONES_LIMIT = 6'h20; // Ones-run threshold, sized
    // ------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------
    localparam int unsigned CMD_RW_POS = 6;    // 1 = read next transfer
    localparam int unsigned CMD_ADDR_LSB = 0;  // Register address, 4 bits
    // ------------------------------------------------------------
    // Register addresses and widths
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0; // Status register
    localparam logic [3:0] ADDR_MAIN = 4'h4;   // Main result register
    localparam logic [3:0] ADDR_AUX = 4'h5;    // Aux result register
    localparam logic [4:0] LEN_CMD = 5'h08;    // Command word length
    localparam logic [4:0] LEN_BYTE = 5'h08;   // Byte register length
    localparam logic [4:0] LEN_WIDE = 5'h18;   // Result register length
    localparam int unsigned MAIN_RDY_POS = 7;  // main_ready_bit position
    localparam int unsigned AUX_RDY_POS = 6;   // aux_ready_bit position
    localparam logic [23:0] REG_RESET = 24'h000000; // Power-on value
    // ------------------------------------------------------------
    // Host clock divider: half period of the serial clock in mclk cycles
    // ------------------------------------------------------------
    localparam int unsigned SCLK_HALF_NS = 200; // Half period in ns
    localparam int unsigned MCLK_NS = 10;       // mclk period in ns
    localparam logic [7:0] SCLK_HALF_CYC =
        8'((SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS);
    // ------------------------------------------------------------
    // Phase of the device shift logic
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ASRP_CMD = 2'b00,   // Next transfer is a command word
        ASRP_WR = 2'b01,    // Next transfer writes the target register
        ASRP_RD = 2'b10     // Next transfer reads the target register
    } asrp_phase_t;
endpackage

// ---- core/asrp_if.sv ----
// Interface carrying the five serial port wires between host and device.
// Assumes the bench resolves the shared data line from the enable.
`timescale 1ns/100ps
`default_nettype none
interface asrp_if;
    logic csN;        // Chip select, low selects
    logic sclk;       // Serial clock from host
    logic din;        // Data into device
    logic dout;       // Data out of device
    logic doutOe;     // High while device drives dout
    logic rdyN;       // Data ready, low when a result waits
    modport device (input csN, input sclk, input din,
        output dout, output doutOe, output rdyN);
    modport host (output csN, output sclk, output din,
        input dout, input doutOe, input rdyN);
endinterface
`default_nettype wire

// ---- core/asrp_sync.sv ----
// Two-flop synchroniser for the serial pins seen by the device.
// Assumes async inputs and mclk; first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module asrp_sync
#(
    parameter int unsigned W = 3
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed
    {
        logic [W-1:0] meta;  // First stage
        logic [W-1:0] sync;  // Second stage
    } asrp_sync_t;
    asrp_sync_t st_ff;
    asrp_sync_t nxt_st;
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st.meta = async_in;
        nxt_st.sync = st_ff.meta;
    end
    // Register the stages
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    assign sync_out = st_ff.sync;
endmodule
`default_nettype wire

// ---- core/asrp_device.sv ----
// Device end of the serial register port: command framing, register file,
// data-ready handling and the ones-run reset.
// Assumes pins arrive from another domain and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module asrp_device
(
    input wire logic mclk,
    input wire logic sys_rst,
    asrp_if.device port,
    input wire logic mainNew,            // Pulse: main result to load
    input wire logic auxNew,             // Pulse: aux result to load
    input wire logic [23:0] mainResult,  // Main converter word
    input wire logic [23:0] auxResult,   // Aux converter word
    output logic [7:0] writeAddr,        // Address of last register write
    output logic [23:0] writeData,       // Data of last register write
    output logic writeStrobe             // One-cycle write pulse
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        asrp_pkg::asrp_phase_t phase;   // Pending transfer kind
        logic [3:0] target;             // Pending target register
        logic [23:0] shIn;              // Input shift register
        logic [23:0] shOut;             // Output shift register
        logic [4:0] bitCnt;             // Bits taken this transfer
        logic [5:0] onesCnt;            // Consecutive ones seen
        logic sclkPrev;                 // Last sampled clock
        logic csPrev;                   // Last sampled select
        logic [23:0] mainReg;           // Main result register
        logic [23:0] auxReg;            // Aux result register
        logic [15:0][7:0] regs;         // Byte registers, by address
        logic mainRdy;                  // Main result unread
        logic auxRdy;                   // Aux result unread
        logic dout;                     // Data out pin
        logic doutOe;                   // Data out enable
        logic rdyN;                     // Ready pin
        logic [7:0] wAddr;              // Write address out
        logic [23:0] wData;             // Write data out
        logic wStb;                     // Write strobe out
    } asrp_dev_t;
    asrp_dev_t st_ff;
    asrp_dev_t nxt_st;
    logic [2:0] pinSync;   // Synchronised csN, sclk, din
    logic csS;             // Select, synchronised
    logic sclkS;           // Serial clock, synchronised
    logic dinS;            // Data in, synchronised
    logic [4:0] xferLen;   // Length of the pending transfer
    logic [23:0] loadWord; // Word loaded for a read
    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    asrp_sync #(.W(3)) u_sync
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in({port.csN, port.sclk, port.din}),
        .sync_out(pinSync)
    );
    assign csS = pinSync[2];
    assign sclkS = pinSync[1];
    assign dinS = pinSync[0];
    // Transfer length and read word from the pending target
    always_comb
    begin
        xferLen = asrp_pkg::LEN_BYTE;
        loadWord = {16'h0000, st_ff.regs[st_ff.target]};
        if (st_ff.phase == asrp_pkg::ASRP_CMD)
        begin
            xferLen = asrp_pkg::LEN_CMD;
        end
        else if (st_ff.target == asrp_pkg::ADDR_MAIN ||
            st_ff.target == asrp_pkg::ADDR_AUX)
        begin
            xferLen = asrp_pkg::LEN_WIDE;
        end
        // Status carries both ready bits for polling
        if (st_ff.target == asrp_pkg::ADDR_STATUS)
        begin
            loadWord = asrp_pkg::REG_RESET;
            loadWord[asrp_pkg::MAIN_RDY_POS] = st_ff.mainRdy;
            loadWord[asrp_pkg::AUX_RDY_POS] = st_ff.auxRdy;
        end
        else if (st_ff.target == asrp_pkg::ADDR_MAIN)
        begin
            loadWord = st_ff.mainReg;    // Re-readable
        end
        else if (st_ff.target == asrp_pkg::ADDR_AUX)
        begin
            loadWord = st_ff.auxReg;
        end
    end
    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic rise;
        logic fall;
        logic csFall;
        rise = 1'b0;
        fall = 1'b0;
        csFall = 1'b0;
        nxt_st = st_ff;
        nxt_st.wStb = 1'b0;
        nxt_st.sclkPrev = sclkS;
        nxt_st.csPrev = csS;
        // Edges only count while selected
        rise = !csS && sclkS && !st_ff.sclkPrev;
        fall = !csS && !sclkS && st_ff.sclkPrev;
        csFall = !csS && st_ff.csPrev;
        if (csS)
        begin
            // Abort partial transfer, keep phase and target
            nxt_st.bitCnt = 5'h00;
            nxt_st.doutOe = 1'b0;
        end
        if ((csFall || fall) && st_ff.phase == asrp_pkg::ASRP_RD &&
            st_ff.bitCnt == 5'h00)
        begin
            // MSB out at select fall, even with clock low, or at the
            // first falling edge after the command
            nxt_st.shOut = loadWord << (5'h18 - xferLen);
            nxt_st.dout = loadWord[xferLen - 5'h01];
            nxt_st.doutOe = 1'b1;
        end
        else if (fall && st_ff.phase == asrp_pkg::ASRP_RD)
        begin
            // Next bit out on the falling edge
            nxt_st.shOut = {st_ff.shOut[22:0], 1'b0};
            nxt_st.dout = st_ff.shOut[22];
        end
        if (rise)
        begin
            // Sample MSB first on rising edge
            nxt_st.shIn = {st_ff.shIn[22:0], dinS};
            nxt_st.onesCnt = dinS ? ((st_ff.onesCnt ==
                asrp_pkg::ONES_LIMIT) ? st_ff.onesCnt :
                st_ff.onesCnt + 6'h01) : 6'h00;
            nxt_st.bitCnt = st_ff.bitCnt + 5'h01;
            if (st_ff.phase == asrp_pkg::ASRP_CMD &&
                st_ff.bitCnt + 5'h01 == xferLen)
            begin
                // Command decides direction and target
                nxt_st.bitCnt = 5'h00;
                nxt_st.target = st_ff.shIn[2:0] == 3'h0 &&
                    dinS == 1'b0 ? 4'h0 : {st_ff.shIn[2:0], dinS};
                nxt_st.phase = st_ff.shIn[asrp_pkg::CMD_RW_POS - 1] ?
                    asrp_pkg::ASRP_RD : asrp_pkg::ASRP_WR;
            end
            else if (st_ff.phase == asrp_pkg::ASRP_WR &&
                st_ff.bitCnt + 5'h01 == xferLen)
            begin
                // Store written data into the target
                nxt_st.bitCnt = 5'h00;
                nxt_st.phase = asrp_pkg::ASRP_CMD;
                nxt_st.wAddr = {4'h0, st_ff.target};
                nxt_st.wData = {st_ff.shIn[22:0], dinS};
                nxt_st.wStb = 1'b1;
                nxt_st.regs[st_ff.target] = {st_ff.shIn[6:0], dinS};
            end
            else if (st_ff.phase == asrp_pkg::ASRP_RD &&
                st_ff.bitCnt + 5'h01 == xferLen)
            begin
                // Last bit taken: release on this edge
                nxt_st.bitCnt = 5'h00;
                nxt_st.phase = asrp_pkg::ASRP_CMD;
                nxt_st.doutOe = 1'b0;
                // Read done clears ready of that result
                if (st_ff.target == asrp_pkg::ADDR_MAIN)
                begin
                    nxt_st.mainRdy = 1'b0;
                end
                if (st_ff.target == asrp_pkg::ADDR_AUX)
                begin
                    nxt_st.auxRdy = 1'b0;
                end
            end
            if (dinS && st_ff.onesCnt + 6'h01 >= asrp_pkg::ONES_LIMIT)
            begin
                // Ones run resets port and registers
                nxt_st.phase = asrp_pkg::ASRP_CMD;
                nxt_st.bitCnt = 5'h00;
                nxt_st.target = 4'h0;
                nxt_st.mainReg = asrp_pkg::REG_RESET;
                nxt_st.auxReg = asrp_pkg::REG_RESET;
                nxt_st.mainRdy = 1'b0;
                nxt_st.auxRdy = 1'b0;
                nxt_st.doutOe = 1'b0;
                nxt_st.wAddr = 8'h00;
                nxt_st.wData = asrp_pkg::REG_RESET;
                nxt_st.regs = {16{asrp_pkg::REG_RESET[7:0]}};
            end
        end
        // Result update: load and ready high in the same cycle
        if (mainNew)
        begin
            nxt_st.mainReg = mainResult;
            nxt_st.mainRdy = 1'b1;
        end
        if (auxNew)
        begin
            nxt_st.auxReg = auxResult;
            nxt_st.auxRdy = 1'b1;
        end
        // Ready low while any result waits, high on update cycle
        nxt_st.rdyN = (mainNew || auxNew) ? 1'b1 :
            !(st_ff.mainRdy || st_ff.auxRdy);
    end
    // ------------------------------------------------------------
    // State register; reset pin restores command phase
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= '0;
            st_ff.rdyN <= 1'b1;
            st_ff.sclkPrev <= 1'b1;
            st_ff.csPrev <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    assign port.dout = st_ff.dout;
    assign port.doutOe = st_ff.doutOe;
    assign port.rdyN = st_ff.rdyN;
    assign writeAddr = st_ff.wAddr;
    assign writeData = st_ff.wData;
    assign writeStrobe = st_ff.wStb;
endmodule
`default_nettype wire

// ---- core/asrp_host.sv ----
// Host end: runs one command-plus-data access or a ones-run recovery.
// Assumes the device end shares mclk; dout is synchronised here.
`timescale 1ns/100ps
`default_nettype none
module asrp_host
(
    input wire logic mclk,
    input wire logic sys_rst,
    asrp_if.host port,
    input wire logic start,          // Pulse: begin access
    input wire logic recover,        // Pulse: send ones-run recovery
    input wire logic [7:0] cmd,      // Command word
    input wire logic [4:0] dataLen,  // Data bits after command
    input wire logic [23:0] wrData,  // Data for a write
    output logic busy,               // Access in progress
    output logic [23:0] rdData,      // Data read back
    output logic done                // One-cycle end pulse
);
    typedef struct packed
    {
        logic act;          // Transfer running
        logic [7:0] div;    // Clock divider
        logic [5:0] cnt;    // Bits left in phase
        logic inData;       // In data phase
        logic isRec;        // Recovery run
        logic [23:0] tx;    // Bits to send
        logic [23:0] rx;    // Bits received
        logic [4:0] len;    // Data length
        logic csN;
        logic sclk;
        logic din;
        logic done;
        logic [1:0] doutS;  // dout synchroniser
    } asrp_host_t;
    asrp_host_t st_ff;
    asrp_host_t nxt_st;
    // ------------------------------------------------------------
    // Next state: clock idles high between transfers
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.doutS = {st_ff.doutS[0], port.dout};
        if (!st_ff.act)
        begin
            if (recover)
            begin
                // Ones for the full run
                nxt_st = '{act: 1'b1, div: 8'h00, cnt: 6'h28, inData: 1'b1,
                    isRec: 1'b1, tx: 24'hFFFFFF, rx: 24'h0, len: 5'h0,
                    csN: 1'b0, sclk: 1'b1, din: 1'b1, done: 1'b0,
                    doutS: st_ff.doutS};
            end
            else if (start)
            begin
                nxt_st = '{act: 1'b1, div: 8'h00, cnt: 6'h08, inData: 1'b0,
                    isRec: 1'b0, tx: {cmd, 16'h0000}, rx: 24'h0,
                    len: dataLen, csN: 1'b0, sclk: 1'b1, din: cmd[7],
                    done: 1'b0, doutS: st_ff.doutS};
            end
        end
        else if (st_ff.div + 8'h01 < asrp_pkg::SCLK_HALF_CYC)
        begin
            nxt_st.div = st_ff.div + 8'h01;
        end
        else
        begin
            nxt_st.div = 8'h00;
            if (st_ff.cnt == 6'h00)
            begin
                // Select rises half a period after the last rising
                // edge, so the device still takes that bit
                nxt_st.act = 1'b0;
                nxt_st.csN = 1'b1;
                nxt_st.done = 1'b1;
            end
            else if (!st_ff.sclk)
            begin
                // Rising edge: device samples, host captures
                nxt_st.sclk = 1'b1;
                nxt_st.rx = {st_ff.rx[22:0], st_ff.doutS[1]};
                nxt_st.tx = {st_ff.tx[22:0], st_ff.isRec};
                nxt_st.cnt = st_ff.cnt - 6'h01;
                if (st_ff.cnt == 6'h01 && !st_ff.inData &&
                    st_ff.len != 5'h00)
                begin
                    nxt_st.inData = 1'b1;
                    nxt_st.cnt = {1'b0, st_ff.len};
                    nxt_st.tx = wrData << (5'h18 - st_ff.len);
                end
            end
            else
            begin
                nxt_st.sclk = 1'b0;
                nxt_st.din = st_ff.tx[23];
            end
        end
    end
    // Register the state
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= '0;
            st_ff.csN <= 1'b1;
            st_ff.sclk <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    assign port.csN = st_ff.csN;
    assign port.sclk = st_ff.sclk;
    assign port.din = st_ff.din;
    assign busy = st_ff.act;
    assign rdData = st_ff.rx;
    assign done = st_ff.done;
endmodule
`default_nettype wire

// ---- sim/asrp_asserts.sv ----
// Checker on the five port wires between host end and device end.
// Assumes one mclk domain and sys_rst asynchronous, active high.
`timescale 1ns/100ps
`default_nettype none
module asrp_asserts
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic doutOe,
    input wire logic rdyN
);
    // ------------------------------------------------------------
    // Helper counters, all saturating
    // ------------------------------------------------------------
    logic [3:0] sinceFall_ff; // Cycles since sclk or csN fell
    logic [3:0] rises_ff; // Rising sclk edges in this frame
    logic [2:0] csHigh_ff; // Cycles with csN high
    logic [5:0] ones_ff; // Ones taken in a row
    // Counts edges and runs as the wires show them
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sinceFall_ff <= 4'hF;
            rises_ff <= 4'h0;
            csHigh_ff <= 3'h0;
            ones_ff <= 6'h00;
        end
        else
        begin
            sinceFall_ff <= ($fell(sclk) || $fell(csN)) ? 4'h0 :
                sinceFall_ff + {3'h0, ~&sinceFall_ff};
            rises_ff <= csN ? 4'h0 :
                rises_ff + {3'h0, $rose(sclk) && ~&rises_ff};
            csHigh_ff <= csN ? csHigh_ff + {2'h0, ~&csHigh_ff} : 3'h0;
            if ($rose(sclk) && !csN)
                ones_ff <= din ? ones_ff + {5'h00, ~&ones_ff} : 6'h00;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_deselected;
        csN [*5];
    endsequence
    sequence s_ones_done;
        $rose(sclk) && din && !csN && ones_ff == 6'h1F;
    endsequence
    property p_reset_quiet;
        disable iff (1'b0) sys_rst |-> rdyN && !doutOe;
    endproperty
    property p_idle_sel_off;
        s_deselected |-> !doutOe;
    endproperty
    property p_change_at_fall;
        doutOe && $past(doutOe) && $changed(dout) |-> sinceFall_ff < 4'h8;
    endproperty
    property p_drive_in_frame;
        $rose(doutOe) |-> csHigh_ff == 3'h0;
    endproperty
    property p_cmd_first;
        $rose(doutOe) |-> rises_ff >= 4'h8;
    endproperty
    property p_ones_quiet;
        s_ones_done |-> ##[2:8] !doutOe;
    endproperty
    property p_ready_after_read;
        // A one-cycle blip marks a result update, not a read
        $rose(rdyN) |-> csHigh_ff < 3'h6 or ##1 !rdyN;
    endproperty
    property p_clock_idle_high;
        csN [*3] |-> sclk;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("port not quiet in reset");
    a_idle_sel_off: assert property (p_idle_sel_off)
        else $error("dout driven while deselected");
    a_change_at_fall: assert property (p_change_at_fall)
        else $error("dout changed away from falling clock");
    a_drive_in_frame: assert property (p_drive_in_frame)
        else $error("dout enabled outside a frame");
    a_cmd_first: assert property (p_cmd_first)
        else $error("dout enabled before command word");
    a_ones_quiet: assert property (p_ones_quiet)
        else $error("dout still driven after ones run");
    a_ready_after_read: assert property (p_ready_after_read)
        else $error("ready rose away from an access");
    a_clock_idle_high: assert property (p_clock_idle_high)
        else $error("serial clock not idle high");
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Bench: host end drives device end through the port interface.
// Assumes both ends share mclk; results are loaded by pulses here.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic mclk, sys_rst, start, recover, mainNew, auxNew;
    logic busy, done, writeStrobe;
    logic [7:0] cmd, writeAddr;
    logic [4:0] dataLen;
    logic [23:0] wrData, rdData, mainResult, auxResult, writeData;
    logic [31:0] seed, failures, n_tests, v, m, x;
    logic [48:0] rq[$]; // Access notes: read flag, mask, value
    logic [11:0] wq[$]; // Write notes: address, byte
    logic [48:0] note;
    int k;
    asrp_if link();
    asrp_device asrp_device_inst (.mclk(mclk), .sys_rst(sys_rst),
        .port(link), .mainNew(mainNew), .auxNew(auxNew),
        .mainResult(mainResult), .auxResult(auxResult),
        .writeAddr(writeAddr), .writeData(writeData),
        .writeStrobe(writeStrobe));
    asrp_host asrp_host_inst (.mclk(mclk), .sys_rst(sys_rst), .port(link),
        .start(start), .recover(recover), .cmd(cmd), .dataLen(dataLen),
        .wrData(wrData), .busy(busy), .rdData(rdData), .done(done));
    asrp_asserts asrp_asserts_inst (.mclk(mclk), .sys_rst(sys_rst),
        .csN(link.csN), .sclk(link.sclk), .din(link.din),
        .dout(link.dout), .doutOe(link.doutOe), .rdyN(link.rdyN));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Compares one seen value with its expectation
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Waits, bounded, until the host end is idle again
    task automatic waitIdle();
        int i;
        repeat (4) @(posedge mclk);
        for (i = 0; busy && i < 4000; i++)
            @(posedge mclk);
        if (i >= 4000)
        begin
            failures = failures + 1;
            print_verdict();
        end
        repeat (30) @(posedge mclk);
    endtask
    // One access: command word, then len data bits
    task automatic acc(input logic [7:0] c, input logic [4:0] len,
        input logic [23:0] d, input logic [23:0] e);
        rq.push_back({c[6], ~(24'hFFFFFF << len), e});
        if (!c[6])
            wq.push_back({c[3:0], d[7:0]});
        @(posedge mclk);
        cmd <= c;
        dataLen <= len;
        wrData <= d;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        waitIdle();
    endtask
    // Loads a result into one converter output
    task automatic load(input logic aux, input logic [23:0] val);
        mainResult <= val;
        auxResult <= val;
        mainNew <= !aux;
        auxNew <= aux;
        @(posedge mclk);
        mainNew <= 1'b0;
        auxNew <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    // ------------------------------------------------------------
    // Clock and result monitor
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Takes the oldest note when the design reports a result
    always @(posedge mclk)
    begin
        if (done && rq.size() > 0)
        begin
            note = rq.pop_front();
            if (note[48])
                chk({8'h00, rdData & note[47:24]}, {8'h00, note[23:0]});
        end
        if (writeStrobe && wq.size() > 0)
            chk({20'h0, writeAddr[3:0], writeData[7:0]}, {20'h0, wq.pop_front()});
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'hC2C79EF7;
        failures = 0;
        n_tests = 0;
        {sys_rst, start, recover, mainNew, auxNew} = 5'h10;
        {cmd, dataLen, wrData, mainResult, auxResult} = 85'h0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk({31'h0, link.rdyN}, 32'h1);
        acc(8'h40, 5'h08, 24'h0, 24'h00);
        for (k = 0; k < 4; k++)
        begin
            v = rnd();
            acc(8'(k + 6), 5'h08, {16'h0, v[7:0]}, 24'h0);
            acc(8'(k + 70), 5'h08, 24'h0, {16'h0, v[7:0]});
        end
        m = rnd();
        x = rnd();
        load(1'b0, m[23:0]);
        chk({31'h0, link.rdyN}, 32'h0);
        acc(8'h40, 5'h08, 24'h0, 24'h80);
        load(1'b1, x[23:0]);
        acc(8'h40, 5'h08, 24'h0, 24'hC0);
        acc(8'h44, 5'h18, 24'h0, m[23:0]);
        chk({31'h0, link.rdyN}, 32'h0);
        acc(8'h45, 5'h18, 24'h0, x[23:0]);
        chk({31'h0, link.rdyN}, 32'h1);
        acc(8'h44, 5'h18, 24'h0, m[23:0]);
        acc(8'h07, 5'h08, 24'h00005A, 24'h0);
        load(1'b0, x[23:0]);
        recover <= 1'b1;
        @(posedge mclk);
        recover <= 1'b0;
        waitIdle();
        chk({31'h0, link.rdyN}, 32'h1);
        acc(8'h47, 5'h08, 24'h0, 24'h00);
        acc(8'h40, 5'h08, 24'h0, 24'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
